// >>> common/pio_port_regs.vh
// constants for the shared parallel i/o port: offsets, layouts, reset values
// assumes a 16-bit internal data bus and one instruction clock
// How it works
// - active peripheral drive turns the port's own driver off; pin stays readable
// - enabled but idle peripheral lets the latch drive the pin
// - each pin has a direction bit, a latch bit and a pin-state bit
// - direction 1 means input, driver off; 0 means output
// - reset sets every implemented direction bit, so all pins are inputs
// - latch reads return the latch; latch writes change only the latch
// - pin-state reads return pin levels; pin-state writes go to the latch
// - unimplemented bits read zero in direction, latch and pin-state
// - non-shared pins are dedicated ports; a peripheral never owns their pad
// - shared pins: a driving peripheral (enable and drive both set) wins the data and enable multiplexers
// - analog config and direction jointly govern converter-capable pins
// - analog pin set to output still drives the latch level
// - analog-configured pins with direction 1 (input) read zero in the pin-state register
`ifndef PIO_PORT_REGS_VH
`define PIO_PORT_REGS_VH

`define PIO_WIDTH         16
`define PIO_ADDR_WIDTH    2
// register selects, word offsets within the port
`define PIO_SEL_DIR       2'h0
`define PIO_SEL_PINS      2'h1
`define PIO_SEL_LATCH     2'h2
`define PIO_SEL_NONE      2'h3
// reset values
`define PIO_LATCH_RESET   16'h0000
`define PIO_SAMPLE_RESET  16'h0000
// default variant: all bits implemented, all shared, none analog-capable
`define PIO_IMPL_DEFAULT  16'hFFFF
`define PIO_SHARED_DEFAULT 16'hFFFF
`define PIO_ANALOG_DEFAULT 16'h0000

`endif

// >>> core/pio_pad_mux.v
// output ownership multiplexer for the pads of one port
// assumes peripheral enable and drive strobes are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none

module pio_pad_mux #(
  parameter [15:0] SHARED_MASK = 16'hFFFF
) (
  // port side
  input  wire [15:0] latchVal,
  input  wire [15:0] dirVal,
  // peripheral side
  input  wire [15:0] periphEnable,
  input  wire [15:0] periphDrive,
  input  wire [15:0] periphData,
  input  wire [15:0] periphOe,
  // pad side
  output wire [15:0] padOutNext,
  output wire [15:0] padOeNext
);

  wire [15:0] periphOwns;

  assign periphOwns = periphEnable & periphDrive & SHARED_MASK;

  // direction 0 drives latch, even when analog
  assign padOutNext = (periphOwns & periphData) | (~periphOwns & latchVal);
  assign padOeNext  = (periphOwns & periphOe) | (~periphOwns & ~dirVal);

endmodule // pio_pad_mux

`default_nettype wire

// >>> core/shared_parallel_io_port.v
// one 16-bit parallel i/o port with latch, direction and pin-read paths
// assumes a single-cycle register port on sys_clk; pad is outside this block
`timescale 1ns/1ps
`default_nettype none
`include "pio_port_regs.vh"

module shared_parallel_io_port #(
  parameter [15:0] IMPL_MASK   = `PIO_IMPL_DEFAULT,
  parameter [15:0] SHARED_MASK = `PIO_SHARED_DEFAULT,
  parameter [15:0] ANALOG_MASK = `PIO_ANALOG_DEFAULT
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // register port
  input  wire [1:0]  regSel,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  // analog pin configuration, 1 = digital, 0 = analog input
  input  wire [15:0] analogPinConfig,
  // peripheral side
  input  wire [15:0] periphEnable,
  input  wire [15:0] periphDrive,
  input  wire [15:0] periphData,
  input  wire [15:0] periphOe,
  // pad side
  input  wire [15:0] padIn,
  output reg  [15:0] padOut,
  output reg  [15:0] padOe,
  // state views
  output reg  [15:0] dirView,
  output reg  [15:0] latchView
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [15:0] dir_q;
  reg  [15:0] dir_d;
  reg  [15:0] latch_q;
  reg  [15:0] latch_d;
  reg  [15:0] sample_q;
  reg  [15:0] rdata_d;
  wire [15:0] padOutNext;
  wire [15:0] padOeNext;
  wire [15:0] analogIn;

  // bits that are analog channels on analog-capable pins
  // analog config plus direction govern these pins
  assign analogIn = ANALOG_MASK & ~analogPinConfig & dir_q;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always @* begin
    dir_d   = dir_q;
    latch_d = latch_q;
    if (regWrite) begin
      case (regSel)
        `PIO_SEL_DIR: begin
          dir_d = regWdata & IMPL_MASK;
        end
        // latch write stores only the latch
        `PIO_SEL_LATCH: begin
          latch_d = regWdata & IMPL_MASK;
        end
        `PIO_SEL_PINS: begin
          latch_d = regWdata & IMPL_MASK;
        end
        default: begin
          dir_d = dir_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads; unimplemented bits masked to zero
  always @* begin
    rdata_d = 16'h0000;
    if (regRead) begin
      case (regSel)
        `PIO_SEL_DIR:   rdata_d = dir_q & IMPL_MASK;
        `PIO_SEL_LATCH: rdata_d = latch_q & IMPL_MASK;
        `PIO_SEL_PINS:  rdata_d = sample_q & IMPL_MASK & ~analogIn;
        default:        rdata_d = 16'h0000;
      endcase
    end
  end

  pio_pad_mux #(
    .SHARED_MASK (SHARED_MASK)
  ) u_mux (
    .latchVal     (latch_q),
    .dirVal       (dir_q),
    .periphEnable (periphEnable),
    .periphDrive  (periphDrive),
    .periphData   (periphData),
    .periphOe     (periphOe),
    .padOutNext   (padOutNext),
    .padOeNext    (padOeNext)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // all implemented pins come up as inputs
      dir_q     <= IMPL_MASK;
      latch_q   <= `PIO_LATCH_RESET;
      sample_q  <= `PIO_SAMPLE_RESET;
      regRdata  <= 16'h0000;
      padOut    <= 16'h0000;
      padOe     <= 16'h0000;
      dirView   <= 16'h0000;
      latchView <= 16'h0000;
    end else begin
      dir_q     <= dir_d & IMPL_MASK;
      latch_q   <= latch_d;
      sample_q  <= padIn;
      regRdata  <= rdata_d;
      padOut    <= padOutNext & IMPL_MASK;
      padOe     <= padOeNext & IMPL_MASK;
      dirView   <= dir_q & IMPL_MASK;
      latchView <= latch_q & IMPL_MASK;
    end
  end

endmodule // shared_parallel_io_port

`default_nettype wire

// >>> test/pad_partner.sv
// pad model: port drive wins, an outside level elsewhere
// assumes the outside level is a new random value each cycle
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  input wire logic [15:0] padOut, padOe, extLevel,
  output logic [15:0]     padIn
);
  assign padIn = padOut & padOe | extLevel & ~padOe;
endmodule // pad_partner
`default_nettype wire

// >>> test/pio_port_chk.sv
// port assertions on pads and read data
// assumes it is bound onto the port block
`timescale 1ns/1ps
`default_nettype none
module pio_port_chk #(parameter [15:0] IMPL_MASK = 16'hFFFF, SHARED_MASK = 16'hFFFF, ANALOG_MASK = 16'h0000) (
  input wire logic        sys_clk, rst, regWrite, regRead,
  input wire logic [1:0]  regSel,
  input wire logic [15:0] regWdata, regRdata, analogPinConfig, periphEnable, periphDrive, periphData,
  input wire logic [15:0] periphOe, padIn, padOut, padOe, dirView, latchView);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [15:0] own = periphEnable & periphDrive & SHARED_MASK;
  sequence latchWr; regWrite && regSel[1] != regSel[0]; endsequence
  dirRd_a: assert property (regRead && regSel == 2'h0 |=> regRdata == dirView) else $error("dir read");
  latRd_a: assert property (regRead && regSel == 2'h2 |=> regRdata == latchView) else $error("latch read");
  pinRd_a: assert property (!$past(rst) && regRead && regSel == 2'h1 |=> regRdata ==
    ($past(padIn, 2) & IMPL_MASK & ~(ANALOG_MASK & ~$past(analogPinConfig) & dirView))) else $error("pin read");
  latWr_a: assert property (latchWr |-> ##2 latchView == ($past(regWdata, 2) & IMPL_MASK))
    else $error("latch write");
  rstDir_a: assert property ($past(rst, 2) && !$past(rst) |-> dirView == IMPL_MASK) else $error("reset dir");
  perOwn_a: assert property (!$past(rst) |-> ((padOe ^ $past(periphOe)) & $past(own) & IMPL_MASK) == 0)
    else $error("peripheral enable");
  portOwn_a: assert property (!$past(rst) |-> ((padOe ^ ~dirView) & ~$past(own) & IMPL_MASK) == 0)
    else $error("port enable");
  unimpl_a: assert property (((dirView | latchView) & ~IMPL_MASK) == 0) else $error("unimplemented bits");
endmodule // pio_port_chk
bind shared_parallel_io_port pio_port_chk #(.IMPL_MASK(IMPL_MASK), .SHARED_MASK(SHARED_MASK),
  .ANALOG_MASK(ANALOG_MASK)) pio_port_chk_i (.*);
`default_nettype wire

// >>> test/tb_top.sv
// bench: random traffic, model checked every cycle
// assumes the checker binds itself in
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam [15:0] IMP = 16'h7FFF, AN = 16'h00F0, SHR = 16'hFF0F;
  logic        sys_clk = 0, rst = 1, regWrite = 0, regRead = 0;
  logic [1:0]  regSel = 0;
  logic [15:0] regWdata = 0, analogPinConfig = 0, periphEnable = 0, periphDrive = 0, periphData = 0;
  logic [15:0] periphOe = 0, extLevel = 0, dir, lat, smp, own, eRd, eOe, eOut, eDir, eLat;
  logic [31:0] rnd;
  wire [15:0]  regRdata, padIn, padOut, padOe, dirView, latchView;
  integer      seed = 32'hd32e, bad_count = 0, total_checks = 0;
  // dedicated pins 7:4 never hand the pad to a peripheral
  shared_parallel_io_port #(.IMPL_MASK(IMP), .SHARED_MASK(SHR), .ANALOG_MASK(AN)) shared_parallel_io_port_i (.*);
  pad_partner pad_partner_i (.*);
  task chk(input string n, input logic [15:0] e, s);
    total_checks++;
    bad_count += (s !== e);
    if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
  endtask
  task end_of_test;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    repeat (300) @(posedge sys_clk);
    end_of_test;
  end
  initial begin
    repeat (400) @(posedge sys_clk);
    bad_count++;
    end_of_test;
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      dir = IMP;
      {lat, smp, eRd, eOe, eOut, eDir, eLat} = '0;
    end else begin
      chk("rd", eRd, regRdata);
      chk("oe", eOe, padOe & IMP);
      chk("out", eOut & eOe, padOut & padOe & IMP);
      chk("dir", eDir, dirView);
      chk("lat", eLat, latchView);
      eDir = dir;
      eLat = lat;
      own = periphEnable & periphDrive & SHR;
      eOe = (own & periphOe | ~own & ~dir) & IMP;
      eOut = own & periphData | ~own & lat;
      eRd = !regRead || regSel == 2'h3 ? 16'h0 : regSel == 2'h0 ? dir : regSel == 2'h2 ? lat
        : smp & IMP & ~(AN & ~analogPinConfig & dir);
      if (regWrite && regSel == 2'h0) dir = regWdata & IMP;
      if (regWrite && regSel[1] != regSel[0]) lat = regWdata & IMP;
      smp = padIn;
    end
    rnd = $random(seed);
    {regWdata, regSel, regWrite} <= rnd[18:0];
    // no read with or right after a write
    regRead <= rnd[19] & ~rnd[0] & ~regWrite;
    {periphEnable, periphDrive} <= $random(seed);
    {periphData, periphOe} <= $random(seed);
    // analog use is not forced to input: both directions exercised
    {analogPinConfig, extLevel} <= $random(seed);
  end
endmodule // tb_top
`default_nettype wire
